//--- include/ddr_pin_pkg.sv
// Shared constants and carriers for the DDR pin command interface.
// Assumes one 100 MHz clock; pins arrive synchronous to it.
package ddr_pin_pkg;
    localparam int ADDR_WIDTH = 14;
    localparam int BANK_WIDTH = 2;
    localparam int LANE_BITS = 8;
    localparam int PRECHARGE_BIT = 10;
    localparam int NUM_BANKS = 4;
    localparam int MODE_WIDTH = 13;
    localparam int ROW_WIDTH_STD = 13;
    localparam int COL_WIDTH = 10;
    localparam int BUF_DEPTH = 2;
    localparam logic [3:0] RESET_OPEN = 4'h0;
    localparam logic [MODE_WIDTH-1:0] RESET_MODE = 13'h0000;

    // Decoded command kinds
    typedef enum logic [2:0]
    {
        CMD_NOP,
        CMD_ACTIVE,
        CMD_READ,
        CMD_WRITE,
        CMD_PRECHARGE,
        CMD_REFRESH,
        CMD_LOAD_MODE,
        CMD_BURST_STOP
    } command_type;

    // Command pins taken on the rising crossing
    typedef struct packed
    {
        logic chip_select_n;
        logic row_strobe_n;
        logic column_strobe_n;
        logic write_strobe_n;
        logic [BANK_WIDTH-1:0] bank;
        logic [ADDR_WIDTH-1:0] address;
    } command_pins_type;

    // Decoded request handed to the core
    typedef struct packed
    {
        command_type kind;
        logic [BANK_WIDTH-1:0] bank;
        logic [ADDR_WIDTH-1:0] address;
        logic auto_precharge;
    } request_type;
endpackage : ddr_pin_pkg

//--- rtl/ddr_command_decoder.sv
// Registers command pins and decodes one command per clock.
// Assumes pins stable at the rising crossing of clock_i.
module ddr_command_decoder
    import ddr_pin_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic enable_i,
    input ddr_pin_pkg::command_pins_type pins_i,
    output ddr_pin_pkg::request_type request_o,
    output logic request_valid_o
);
    command_type kind;

    // Strobe combination into a command kind
    always_comb
    begin
        unique case ({pins_i.row_strobe_n, pins_i.column_strobe_n, // [RULE_08]
                      pins_i.write_strobe_n})
            3'b011: kind = CMD_ACTIVE;
            3'b101: kind = CMD_READ;
            3'b100: kind = CMD_WRITE;
            3'b010: kind = CMD_PRECHARGE;
            3'b001: kind = CMD_REFRESH;
            3'b000: kind = CMD_LOAD_MODE;
            3'b110: kind = CMD_BURST_STOP;
            default: kind = CMD_NOP;
        endcase
    end

    // Take pins on the rising edge only; deselect masks the cycle
    always_ff @(posedge clock_i or negedge reset_n_i) // [RULE_01]
    begin
        if (!reset_n_i)
        begin
            request_o <= '0;
            request_valid_o <= 1'b0;
        end
        else
        begin
            request_valid_o <= enable_i && !pins_i.chip_select_n // [RULE_07]
                && kind != CMD_NOP;
            request_o.kind <= kind;
            request_o.bank <= pins_i.bank;
            request_o.address <= pins_i.address;
            request_o.auto_precharge <= pins_i.address[PRECHARGE_BIT];
        end
    end

    a_deselect_masks: assert property ( // [RULE_07]
        @(posedge clock_i) disable iff (!reset_n_i)
        pins_i.chip_select_n |=> !request_valid_o)
        else $error("command taken while deselected");
endmodule : ddr_command_decoder

//--- rtl/ddr_pin_device.sv
// Device-side pin interface of a low-power DDR DRAM: decode, banks, data.
// Assumes pins synchronous to clock_i; data lanes sampled on each rising edge of clock_i.
//
// Notes on behaviour
// [RULE_01] Address and control pins are taken on the rising clock crossing.
// [RULE_02] Data moves on both clock crossings, two beats per period; code moves one beat per rising edge.
// [RULE_03] Clock gate high runs the device; low stops clocks, buffers, drivers. Code only turns drivers off and stalls the read buffer output.
// [RULE_04] Gate low: idle banks give precharge power-down or self refresh.
// [RULE_05] Gate is synchronous except self-refresh exit, seen without clock.
// [RULE_06] In power-down and self refresh only the clock gate is heard.
// [RULE_07] Chip select low enables decoding; high masks that cycle's command.
// [RULE_08] Command comes from row, column and write strobes with chip select.
// [RULE_09] A byte with its write mask high is not written.
// [RULE_10] Write masks are sampled on both strobe edges like write data.
// [RULE_11] Bank select picks the bank for active, read, write, precharge.
// [RULE_12] Bank select picks which mode register a mode load writes.
// [RULE_13] Active opens the row given on the address inputs.
// [RULE_14] Read and write take a column; precharge bit asks auto precharge.
// [RULE_15] Precharge bit low closes one bank, high closes all banks.
// [RULE_16] Mode load takes its op-code from the address inputs.
// [RULE_17] Data bus is 16 bits narrow or 32 bits wide.
// [RULE_18] Device drives strobes with read data, edge aligned.
// [RULE_19] Each byte lane has its own strobe and write mask.
// [RULE_20] Extra row bit is used only in reduced page size.
// [RULE_21] Controller deselects or sends no-operation when idle.
module ddr_pin_device
    import ddr_pin_pkg::*;
#(
    parameter int DATA_WIDTH = 32,
    parameter bit REDUCED_PAGE = 1'b0,
    parameter int READ_LATENCY = 3,
    parameter int BURST_BEATS = 4,
    parameter int MEM_WORDS = 64
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic clock_gate_i,
    input wire logic self_refresh_exit_i,
    input ddr_pin_pkg::command_pins_type pins_i,
    input wire logic [DATA_WIDTH-1:0] data_i,
    output logic [DATA_WIDTH-1:0] data_o,
    output logic data_oe_o,
    input wire logic [DATA_WIDTH/8-1:0] lane_write_masks_i,
    input wire logic [DATA_WIDTH/8-1:0] lane_strobes_i,
    output logic [DATA_WIDTH/8-1:0] lane_strobes_o,
    output logic lane_strobes_oe_o,
    output logic [NUM_BANKS-1:0] open_banks_o,
    output logic [1:0] power_state_o
);
    localparam int LANES = DATA_WIDTH / LANE_BITS; // [RULE_17] [RULE_19]
    localparam int HALF = DATA_WIDTH;
    localparam int AW = $clog2(MEM_WORDS);

    typedef enum logic [1:0]
    {
        PWR_RUN,
        PWR_PRECHARGE_DOWN,
        PWR_ACTIVE_DOWN,
        PWR_SELF_REFRESH
    } power_type;

    power_type power_reg;
    logic running;
    logic last_refresh_reg;
    request_type request;
    logic request_valid;
    logic [NUM_BANKS-1:0] open_reg;
    logic [ROW_WIDTH_STD:0] row_reg [NUM_BANKS];
    logic [MODE_WIDTH-1:0] mode_reg [NUM_BANKS];
    logic [AW-1:0] col_reg;
    logic [BANK_WIDTH-1:0] burst_bank_reg;
    logic auto_pre_reg;
    logic [3:0] write_left_reg;
    logic [3:0] read_left_reg;
    logic [3:0] latency_reg;
    logic [2*HALF-1:0] read_word;
    logic buf_ready;
    logic buf_valid;
    logic [2*HALF-1:0] buf_data;
    logic beat_second_reg;
    logic [2*HALF-1:0] hold_reg;

    assign running = clock_gate_i && power_reg == PWR_RUN; // [RULE_03]

    ddr_command_decoder decoder (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .enable_i(running), // [RULE_06]
        .pins_i(pins_i),
        .request_o(request),
        .request_valid_o(request_valid)
    );

    // Power state: gate low picks a mode from bank state and last command
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            power_reg <= PWR_RUN;
        else if (power_reg == PWR_SELF_REFRESH)
        begin
            // Exit flag comes from an unclocked detector outside
            if (self_refresh_exit_i && clock_gate_i) // [RULE_05]
                power_reg <= PWR_RUN;
        end
        else if (!clock_gate_i) // [RULE_04]
        begin
            if (|open_reg)
                power_reg <= PWR_ACTIVE_DOWN;
            else if (last_refresh_reg)
                power_reg <= PWR_SELF_REFRESH;
            else
                power_reg <= PWR_PRECHARGE_DOWN;
        end
        else
            power_reg <= PWR_RUN; // [RULE_05]
    end

    // Refresh seen in the cycle before the gate drops means self refresh
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            last_refresh_reg <= 1'b0;
        else if (running)
            last_refresh_reg <= !pins_i.chip_select_n
                && pins_i.row_strobe_n == 1'b0
                && pins_i.column_strobe_n == 1'b0
                && pins_i.write_strobe_n == 1'b1;
    end

    // Bank open flags: activate, precharge and auto precharge
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            open_reg <= RESET_OPEN;
        else if (request_valid)
        begin
            unique case (request.kind)
                CMD_ACTIVE: open_reg[request.bank] <= 1'b1; // [RULE_11]
                CMD_PRECHARGE:
                    if (request.auto_precharge)
                        open_reg <= '0; // [RULE_15]
                    else
                        open_reg[request.bank] <= 1'b0;
                default: ;
            endcase
        end
        else if (auto_pre_reg && write_left_reg == 0 && read_left_reg == 0)
            open_reg[burst_bank_reg] <= 1'b0; // [RULE_14]
    end

    // Row address latched on activate
    always_ff @(posedge clock_i)
    begin
        if (request_valid && request.kind == CMD_ACTIVE) // [RULE_13]
            row_reg[request.bank] <= REDUCED_PAGE ? // [RULE_20]
                request.address : {1'b0, request.address[ROW_WIDTH_STD-1:0]};
    end

    // Mode registers chosen by bank select
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            mode_reg <= '{default: RESET_MODE};
        else if (request_valid && request.kind == CMD_LOAD_MODE)
            mode_reg[request.bank] <= // [RULE_12]
                request.address[MODE_WIDTH-1:0]; // [RULE_16]
    end

    // Burst bookkeeping for reads and writes
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            col_reg <= '0;
            burst_bank_reg <= '0;
            auto_pre_reg <= 1'b0;
            write_left_reg <= '0;
            read_left_reg <= '0;
            latency_reg <= '0;
        end
        else if (request_valid && (request.kind == CMD_READ
            || request.kind == CMD_WRITE))
        begin
            // Low AW bits of bank and column index a small backing store; at 64 words only column bits remain
            col_reg <= AW'({request.bank, request.address[COL_WIDTH-1:0]});
            burst_bank_reg <= request.bank;
            auto_pre_reg <= request.auto_precharge; // [RULE_14]
            write_left_reg <= request.kind == CMD_WRITE ?
                4'(BURST_BEATS / 2) : 4'h0;
            read_left_reg <= request.kind == CMD_READ ?
                4'(BURST_BEATS / 2) : 4'h0;
            latency_reg <= 4'(READ_LATENCY - 1);
        end
        else
        begin
            if (write_left_reg != 0 && !lane_strobes_i[0])
            begin
                write_left_reg <= write_left_reg - 1'b1;
                col_reg <= col_reg + AW'(2);
            end
            if (read_left_reg != 0 && latency_reg != 0)
                latency_reg <= latency_reg - 1'b1;
            else if (read_left_reg != 0 && buf_ready)
            begin
                read_left_reg <= read_left_reg - 1'b1;
                col_reg <= col_reg + AW'(2);
            end
            if (write_left_reg == 0 && read_left_reg == 0)
                auto_pre_reg <= 1'b0;
        end
    end

    // Both beats of a pair, one per rising edge; each byte stored only when its mask is low
    for (genvar lane = 0; lane < LANES; lane++)
    begin : g_lane
        logic [7:0] beat0_reg;
        logic mask0_reg;
        logic [7:0] store [MEM_WORDS];
        // First-half beat captured on each rising edge that finds the lane strobe high
        always_ff @(posedge clock_i)
        begin
            if (lane_strobes_i[lane]) // [RULE_10] [RULE_02]
            begin
                beat0_reg <= data_i[lane*8 +: 8];
                mask0_reg <= lane_write_masks_i[lane];
            end
        end
        always_ff @(posedge clock_i)
        begin
            if (write_left_reg != 0 && !lane_strobes_i[lane])
            begin
                if (!mask0_reg) // [RULE_09]
                    store[col_reg] <= beat0_reg;
                if (!lane_write_masks_i[lane]) // [RULE_09] [RULE_10]
                    store[col_reg ^ AW'(1)] <= data_i[lane*8 +: 8];
            end
        end
        // Pair read, even word low
        assign read_word[lane*8 +: 8] = store[col_reg];
        assign read_word[HALF + lane*8 +: 8] = store[col_reg ^ AW'(1)];
    end

    ddr_skid_buffer #(
        .WIDTH(2 * HALF),
        .DEPTH(BUF_DEPTH)
    ) read_buffer (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .in_valid_i(read_left_reg != 0 && latency_reg == 0),
        .in_ready_o(buf_ready),
        .in_data_i(read_word),
        .out_valid_o(buf_valid),
        .out_ready_i(running && !beat_second_reg),
        .out_data_o(buf_data)
    );

    // Read drive: two beats per pair, strobe toggles with each beat
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            data_o <= '0;
            data_oe_o <= 1'b0;
            lane_strobes_o <= '0;
            lane_strobes_oe_o <= 1'b0;
            beat_second_reg <= 1'b0;
            hold_reg <= '0;
        end
        else if (!running) // [RULE_03] drivers off
        begin
            data_oe_o <= 1'b0;
            lane_strobes_oe_o <= 1'b0;
        end
        else if (beat_second_reg)
        begin
            data_o <= hold_reg[2*HALF-1:HALF]; // [RULE_02]
            data_oe_o <= 1'b1;
            lane_strobes_oe_o <= 1'b1;
            lane_strobes_o <= '0; // [RULE_18]
            beat_second_reg <= 1'b0;
        end
        else if (buf_valid)
        begin
            data_o <= buf_data[HALF-1:0];
            hold_reg <= buf_data;
            data_oe_o <= 1'b1;
            lane_strobes_o <= '1; // [RULE_18] edge aligned
            lane_strobes_oe_o <= 1'b1;
            beat_second_reg <= 1'b1;
        end
        else
        begin
            data_oe_o <= 1'b0;
            lane_strobes_oe_o <= 1'b0;
        end
    end

    // Status outputs
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            open_banks_o <= '0;
            power_state_o <= 2'h0;
        end
        else
        begin
            open_banks_o <= open_reg;
            power_state_o <= power_reg;
        end
    end

    a_gate_low_active: assert property ( // [RULE_04]
        @(posedge clock_i) disable iff (!reset_n_i)
        (power_reg == PWR_RUN && !clock_gate_i && |open_reg)
        |=> power_reg == PWR_ACTIVE_DOWN)
        else $error("open row did not give active power-down");
    a_gate_low_idle: assert property ( // [RULE_04]
        @(posedge clock_i) disable iff (!reset_n_i)
        (power_reg == PWR_RUN && !clock_gate_i && open_reg == 0)
        |=> power_reg inside {PWR_PRECHARGE_DOWN, PWR_SELF_REFRESH})
        else $error("idle banks did not give precharge down");
    a_drivers_off: assert property ( // [RULE_03]
        @(posedge clock_i) disable iff (!reset_n_i)
        !running |=> !data_oe_o && !lane_strobes_oe_o)
        else $error("drivers on while stopped");
    a_pins_ignored: assert property ( // [RULE_06]
        @(posedge clock_i) disable iff (!reset_n_i)
        !running |=> !request_valid)
        else $error("command taken in power-down");
    a_activate_opens: assert property ( // [RULE_13]
        @(posedge clock_i) disable iff (!reset_n_i)
        request_valid && request.kind == CMD_ACTIVE
        |=> open_reg[$past(request.bank)])
        else $error("activate left bank closed");
    a_precharge_all: assert property ( // [RULE_15]
        @(posedge clock_i) disable iff (!reset_n_i)
        request_valid && request.kind == CMD_PRECHARGE
        && request.auto_precharge |=> open_reg == 0)
        else $error("precharge all left a bank open");
    a_precharge_one: assert property ( // [RULE_15]
        @(posedge clock_i) disable iff (!reset_n_i)
        request_valid && request.kind == CMD_PRECHARGE
        && !request.auto_precharge
        |=> !open_reg[$past(request.bank)])
        else $error("precharge left bank open");
    a_mode_load: assert property ( // [RULE_12]
        @(posedge clock_i) disable iff (!reset_n_i)
        request_valid && request.kind == CMD_LOAD_MODE
        |=> mode_reg[$past(request.bank)]
            == $past(request.address[MODE_WIDTH-1:0]))
        else $error("mode register not loaded");
    a_two_beats: assert property ( // [RULE_02]
        @(posedge clock_i) disable iff (!reset_n_i)
        $rose(lane_strobes_o[0]) && running |=> !lane_strobes_o[0])
        else $error("read strobe did not toggle");
endmodule : ddr_pin_device

//--- rtl/ddr_skid_buffer.sv
// Two-entry buffer on the read data path.
// Assumes both sides in the single clock domain.
module ddr_skid_buffer #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 2
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    logic [WIDTH-1:0] store_reg [DEPTH];
    logic [$clog2(DEPTH)-1:0] wr_reg;
    logic [$clog2(DEPTH)-1:0] rd_reg;
    logic [$clog2(DEPTH):0] count_reg;
    logic push;
    logic pop;

    assign in_ready_o = count_reg != ($clog2(DEPTH)+1)'(DEPTH);
    assign out_valid_o = count_reg != '0;
    assign out_data_o = store_reg[rd_reg];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // Pointers and occupancy
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wr_reg <= '0;
            rd_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            if (push)
                wr_reg <= wr_reg + 1'b1;
            if (pop)
                rd_reg <= rd_reg + 1'b1;
            count_reg <= count_reg + (push ? 1'b1 : 1'b0)
                - (pop ? 1'b1 : 1'b0);
        end
    end

    // Storage has no reset; only valid entries are read
    always_ff @(posedge clock_i)
    begin
        if (push)
            store_reg[wr_reg] <= in_data_i;
    end
endmodule : ddr_skid_buffer

//--- test/ddr_controller_model.sv
// Behavioural memory controller that drives the device's command and data pins.
// Assumes its tasks are called one at a time from the bench's main process.
module ddr_controller_model
    import ddr_pin_pkg::*;
#(
    parameter int DATA_WIDTH = 32,
    parameter int BURST_BEATS = 4
) (
    input wire logic clock_i,
    output ddr_pin_pkg::command_pins_type pins_o,
    output logic clock_gate_o,
    output logic self_refresh_exit_o,
    output logic [DATA_WIDTH-1:0] data_o,
    output logic data_oe_o,
    output logic [DATA_WIDTH/8-1:0] masks_o,
    output logic [DATA_WIDTH/8-1:0] strobes_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // Strobe codes: row, column, write, all active low
    localparam logic [2:0] WRITE_CODE = 3'h4;
    localparam logic [2:0] REFRESH_CODE = 3'h1;

    // Idle pins: deselected, clock running, bus released
    initial
    begin
        pins_o = '1;
        clock_gate_o = 1'b1;
        self_refresh_exit_o = 1'b0;
        data_o = '0;
        data_oe_o = 1'b0;
        masks_o = '0;
        strobes_o = '0;
    end

    // One command for one rising crossing, then deselect; the address
    // lines turn over so a late sampler never sees a stale value
    task automatic send(input logic cs_n, input logic [2:0] code,
        input logic [1:0] bank, input logic [13:0] addr);
        @(posedge clock_i);
        pins_o <= {cs_n, code, bank, addr};
        @(posedge clock_i);
        pins_o <= {1'b1, 3'h7, ~bank, ~addr};
    endtask : send

    // Write burst: strobe high carries the even beat, low the odd one
    task automatic write_burst(input logic [1:0] bank,
        input logic [13:0] col,
        input logic [DATA_WIDTH-1:0] words [BURST_BEATS],
        input logic [DATA_WIDTH/8-1:0] masks [BURST_BEATS]);
        send(1'b0, WRITE_CODE, bank, col);
        for (int i = 0; i < BURST_BEATS; i++)
        begin
            @(posedge clock_i);
            data_o <= words[i];
            masks_o <= masks[i];
            strobes_o <= (i % 2 == 0) ? '1 : '0;
            data_oe_o <= 1'b1;
        end
        @(posedge clock_i);
        data_o <= ~words[BURST_BEATS-1];
        masks_o <= ~masks[BURST_BEATS-1];
        strobes_o <= '1;
        data_oe_o <= 1'b0;
    endtask : write_burst

    // Refresh, then gate low at once so self refresh is chosen
    task automatic refresh_sleep();
        send(1'b0, REFRESH_CODE, 2'h0, 14'h0000);
        clock_gate_o <= 1'b0;
    endtask : refresh_sleep

    // Gate level and the unclocked self-refresh exit flag
    task automatic set_gate(input logic level, input logic leave);
        @(posedge clock_i);
        clock_gate_o <= level;
        self_refresh_exit_o <= leave;
    endtask : set_gate
endmodule : ddr_controller_model

//--- test/ddr_pin_device_tb.sv
// Self-checking bench for the device pins, driven by the controller model.
// Assumes registered outputs; read beats are checked from a queue of notes.
module ddr_pin_device_tb
    import ddr_pin_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int BEATS = 4;
    localparam logic [2:0] ACTIVE_CODE = 3'h3;
    localparam logic [2:0] READ_CODE = 3'h5;
    localparam logic [2:0] PRECHARGE_CODE = 3'h2;
    localparam logic [13:0] AUTO = 14'h0400;
    localparam logic [13:0] COL = 14'h0008;
    typedef struct packed {logic [31:0] data; logic [3:0] strobes;} beat_type;

    logic clock;
    logic reset_n;
    command_pins_type pins;
    logic gate, leave, ctrl_oe, dev_oe, strobe_oe;
    logic [31:0] ctrl_data, dev_data, bus_level;
    logic [3:0] masks, ctrl_strobes, dev_strobes, strobe_level, open_banks;
    logic [1:0] power_state;
    logic [31:0] merged [BEATS];
    beat_type expected_q[$];
    int errors = 0;
    int comparisons = 0;

    // Wire levels: the device owns the lane while its driver is enabled, else the controller does
    assign bus_level = dev_oe ? dev_data : ctrl_data;
    assign strobe_level = strobe_oe ? dev_strobes : ctrl_strobes;

    // 100 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    ddr_pin_device #(.DATA_WIDTH(32), .BURST_BEATS(BEATS)) ddr_pin_device_inst (
        .clock_i(clock), .reset_n_i(reset_n), .clock_gate_i(gate),
        .self_refresh_exit_i(leave), .pins_i(pins), .data_i(bus_level),
        .data_o(dev_data), .data_oe_o(dev_oe), .lane_write_masks_i(masks),
        .lane_strobes_i(strobe_level), .lane_strobes_o(dev_strobes),
        .lane_strobes_oe_o(strobe_oe), .open_banks_o(open_banks),
        .power_state_o(power_state));

    ddr_controller_model #(.DATA_WIDTH(32), .BURST_BEATS(BEATS)) ctrl (
        .clock_i(clock), .pins_o(pins), .clock_gate_o(gate),
        .self_refresh_exit_o(leave), .data_o(ctrl_data), .data_oe_o(ctrl_oe),
        .masks_o(masks), .strobes_o(ctrl_strobes));

    task automatic check_state(input string what, input logic [31:0] exp,
        input logic [31:0] seen);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check_state

    task automatic check_beat(input beat_type exp, input beat_type seen);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED read beat expected %h seen %h", exp, seen);
        end
    endtask : check_beat

    task automatic close_out();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out

    task automatic cycles(input int n);
        repeat (n) @(posedge clock);
    endtask : cycles

    // Bounded wait for bank flags and power state; a run-out ends the run
    task automatic wait_state(input logic [3:0] banks,
        input logic [1:0] power);
        int i;
        for (i = 0; i < 12; i++)
        begin
            @(negedge clock);
            if (open_banks === banks && power_state === power)
                break;
        end
        check_state("open banks", 32'(banks), 32'(open_banks));
        check_state("power state", 32'(power), 32'(power_state));
        if (i == 12)
            close_out();
    endtask : wait_state

    // All noted beats must come out within a bounded time
    task automatic drain();
        for (int i = 0; i < 40 && expected_q.size() != 0; i++)
            @(negedge clock);
        check_state("beats left", 32'h0, 32'(expected_q.size()));
        if (expected_q.size() != 0)
            close_out();
    endtask : drain

    // Read burst notes: even beat with strobes high, odd with them low
    task automatic note_burst();
        for (int i = 0; i < BEATS; i++)
            expected_q.push_back({merged[i], (i % 2 == 0) ? 4'hf : 4'h0});
    endtask : note_burst

    // Each driven read beat is compared against the oldest note
    always @(posedge clock)
    begin
        if (reset_n === 1'b1 && dev_oe === 1'b1)
        begin
            if (expected_q.size() == 0)
                check_beat('0, {dev_data, dev_strobes});
            else
                check_beat(expected_q.pop_front(),
                    {dev_data, dev_strobes});
        end
    end

    initial
    begin
        logic [31:0] first [BEATS];
        logic [31:0] second [BEATS];
        logic [3:0] mask_set [BEATS];
        logic [3:0] no_mask [BEATS];
        logic [31:0] keep;
        reset_n = 1'b0;
        void'($urandom(32'h7cf7));
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        wait_state(4'h0, 2'h0);
        ctrl.send(1'b1, ACTIVE_CODE, 2'h0, 14'h0123);
        cycles(6);
        wait_state(4'h0, 2'h0);
        $display("test deselect done");
        for (int b = 0; b < 4; b++)
        begin
            ctrl.send(1'b0, ACTIVE_CODE, 2'(b), 14'($urandom_range(0, 8191)));
            wait_state(4'((1 << (b + 1)) - 1), 2'h0);
        end
        ctrl.send(1'b0, PRECHARGE_CODE, 2'h2, 14'h0000);
        wait_state(4'hb, 2'h0);
        ctrl.send(1'b0, PRECHARGE_CODE, 2'h2, AUTO);
        wait_state(4'h0, 2'h0);
        ctrl.send(1'b0, 3'h0, 2'h3, 14'($urandom()));
        $display("test banks done");
        for (int i = 0; i < BEATS; i++)
        begin
            first[i] = $urandom();
            second[i] = $urandom();
            mask_set[i] = 4'($urandom());
            no_mask[i] = 4'h0;
            for (int k = 0; k < 4; k++)
                keep[8*k +: 8] = {8{mask_set[i][k]}};
            merged[i] = (second[i] & ~keep) | (first[i] & keep);
        end
        ctrl.send(1'b0, ACTIVE_CODE, 2'h1, 14'h0042);
        ctrl.write_burst(2'h1, COL, first, no_mask);
        ctrl.write_burst(2'h1, COL, second, mask_set);
        note_burst();
        ctrl.send(1'b0, READ_CODE, 2'h1, COL | AUTO);
        drain();
        wait_state(4'h0, 2'h0);
        $display("test masked write done");
        ctrl.send(1'b0, ACTIVE_CODE, 2'h1, 14'h0042);
        note_burst();
        ctrl.send(1'b0, READ_CODE, 2'h1, COL);
        for (int i = 0; i < 20 && dev_oe !== 1'b1; i++)
            @(negedge clock);
        check_state("read start", 32'h1, 32'(dev_oe));
        if (dev_oe !== 1'b1)
            close_out();
        ctrl.set_gate(1'b0, 1'b0);
        cycles(3);
        ctrl.set_gate(1'b1, 1'b0);
        drain();
        wait_state(4'h2, 2'h0);
        $display("test stalled read done");
        ctrl.send(1'b0, PRECHARGE_CODE, 2'h0, AUTO);
        wait_state(4'h0, 2'h0);
        ctrl.set_gate(1'b0, 1'b0);
        wait_state(4'h0, 2'h1);
        ctrl.send(1'b0, ACTIVE_CODE, 2'h0, 14'h0011);
        ctrl.set_gate(1'b1, 1'b0);
        cycles(4);
        wait_state(4'h0, 2'h0);
        ctrl.send(1'b0, ACTIVE_CODE, 2'h2, 14'h0011);
        wait_state(4'h4, 2'h0);
        ctrl.set_gate(1'b0, 1'b0);
        wait_state(4'h4, 2'h2);
        ctrl.set_gate(1'b1, 1'b0);
        wait_state(4'h4, 2'h0);
        ctrl.send(1'b0, PRECHARGE_CODE, 2'h2, 14'h0000);
        wait_state(4'h0, 2'h0);
        ctrl.refresh_sleep();
        wait_state(4'h0, 2'h3);
        ctrl.set_gate(1'b1, 1'b1);
        wait_state(4'h0, 2'h0);
        ctrl.set_gate(1'b1, 1'b0);
        $display("test power states done");
        close_out();
    end
endmodule : ddr_pin_device_tb
